// ==== inc/octet_pkg.sv ====
/*
 Constants and phase codes for the octet decoder and its arbiter.
 Assumes the slave reports its phase and strobes each octet.
*/
// Overview of operation
// - Top bit zero: matching slave answers selection
// - Priority hold keeps port allegiance after deselection
// - Priority select preempts unless another holds
// - Simultaneous priority selects: one connects, others busy
// - Priority select ends other established selections
// - Both bits preempt unless prior both-bit holder
// - Both-bit allegiance ends on later plain selection
// - Unsupported option bits: never acknowledge selection
// - Facility octet: slave and facility addresses decoded
// - No facility support: never acknowledge facility octet
// - Invalid facility reported in slave status
// - Select status drives only own address bit
// - Unknown bus control: transfer ends without data
// - Bus acknowledge: stable zero with correct parity
// - Slave status: bit7 success, bit6 parity error
// - Interrupt poll: busy, ready, powered answer address
// - Power fail: wind down first, then answer
// - Class poll bits 2,1,0 map classes 3,2,1
// - Several conditions polled: answer on any match
// - Top bit set, low bits nonzero: facility poll
// - Range bit picks facilities 0-7 or 8-15
package octet_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_FAC_VALID = 8'h04;
    localparam logic [7:0] REG_DEV = 8'h08;
    localparam logic [7:0] REG_FAC_LO = 8'h0C;
    localparam logic [7:0] REG_FAC_HI = 8'h10;
    localparam logic [7:0] REG_CTL_OK = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    // Field positions in CFG and DEV
    localparam int CFG_OPT_LSB = 4;
    localparam int CFG_FAC_EN = 8;
    localparam int CFG_HOLD_CLR = 9;
    localparam int DEV_READY = 0;
    localparam int DEV_PON = 1;
    localparam int DEV_BUSY = 2;
    localparam int DEV_CLS_LSB = 3;
    localparam int DEV_PREV_OK = 6;
    localparam int DEV_VEND_LSB = 8;
    localparam int DEV_PF_DONE = 14;
    // Octet bit positions
    localparam int OCT_TOP = 7;
    localparam int OCT_ADDR_LSB = 4;
    localparam int OCT_HOLD = 1;
    localparam int OCT_PSEL = 0;
    localparam int OCT_RANGE = 3;
    localparam int OCT_OK = 7;
    localparam int OCT_PERR = 6;
    localparam int SS_INVAL = 0;
    // Reset values
    localparam logic [2:0] RST_ADDR = 3'h0;
    localparam logic [3:0] RST_OPT = 4'h3;
    localparam logic [15:0] RST_FAC_VALID = 16'hFFFF;
    localparam logic [3:0] RST_CTL_OK = 4'hF;
    // Odd parity: parity bit makes the nine-bit count odd
    localparam logic PAR_ODD = 1'b1;
    // Interface state as seen by this block
    typedef enum logic [2:0] {PH_IDLE, PH_SEL_STATUS, PH_SLV_STATUS, PH_BUSACK,
        PH_REQUEST, PH_REQUACK} phase_t;
endpackage : octet_pkg

// ==== rtl/octet_decoder.sv ====
/*
 Slave octet decoder forming BUS B responses, set up over APB.
 Assumes the surrounding slave sequences states and reports the phase.
*/
`timescale 1ns/1ps
`default_nettype none
module octet_decoder
    import octet_pkg::*;
#(
    parameter int NPORTS = 2,
    parameter int IW = 1
)(
    input wire logic pclk, // Clock, 100 MHz
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic [NPORTS-1:0] sel_out, // Selection active per port
    input wire logic [NPORTS-1:0] sel_state, // Port in SELECT state
    input wire logic [8*NPORTS-1:0] sel_octet, // Selection octet per port
    input wire logic [7:0] bus_a, // BUS A of connected port
    input wire logic bus_a_par, // BUS A parity
    input wire logic mstat_stb, // Master status octet valid
    input wire logic busctl_stb, // Bus control octet valid
    input wire logic req_stb, // Request octet valid
    input wire logic data_perr, // Outbound data parity error
    input wire phase_t bus_phase, // Current interface phase
    output logic [7:0] bus_b_out, // BUS B drive value
    output logic [7:0] bus_b_oe, // BUS B per-bit enable
    output logic bus_b_par_out, // BUS B parity value
    output logic bus_b_par_oe, // BUS B parity enable
    output logic [NPORTS-1:0] port_ack, // Selection acknowledge
    output logic [NPORTS-1:0] port_busy, // Busy per port
    output logic [NPORTS-1:0] port_drop, // Selection terminated
    output logic no_xfer, // End next transfer with no data
    output logic pfail_alert // Power fail wind-down needed
);
    // Software-written control
    logic [2:0] cfg_addr; // Own slave address
    logic [3:0] opt_mask; // Supported option bits
    logic fac_en; // Facility selection supported
    logic hold_clr; // One-cycle reset action
    logic [15:0] fac_valid; // Valid facility numbers
    logic dev_ready; // Ready for use
    logic dev_pon; // Power on
    logic dev_busy; // Busy by the device
    logic [2:0] cls_pend; // Pending classes 3..1
    logic prev_ok; // Previous transfer ok
    logic [4:0] vend; // Vendor status bits 5..1
    logic [47:0] fac_int; // Three class bits per facility
    logic [3:0] ctl_ok; // Recognised control codes
    // Block state
    logic [7:0] mstat_last; // Last master status
    logic [7:0] req_oct; // Last request octet
    logic [3:0] fac_sel; // Selected facility
    logic fac_inval; // Facility not valid
    logic ctl_bad; // Control octet not recognised
    logic perr; // Slave-detected parity error
    logic pf_pending; // Wind-down not yet done
    // Arbiter
    logic [NPORTS-1:0] addressed;
    logic [NPORTS-1:0] hold_bit;
    logic [NPORTS-1:0] prio_bit;
    logic take;
    logic [IW-1:0] conn_idx;
    logic hold;
    logic hold_both;
    // Bus glue
    logic wr; // APB write at completion
    logic par_bad; // BUS A parity fails
    logic [7:0] own_bit; // One-hot own address
    logic [7:0] conn_oct; // Octet of connected port
    logic poll_hit; // Interrupt poll matches
    logic fac_req; // Facility poll for us
    logic [7:0] fac_hit; // Facilities answering
    logic [7:0] next_b;
    logic [7:0] next_oe;
    logic next_par;
    logic next_par_oe;
    logic [31:0] rdata;
    logic hit;

    assign wr = psel && penable && pready && pwrite;
    assign par_bad = ~(^{bus_a, bus_a_par} == PAR_ODD);
    assign own_bit = 8'h01 << cfg_addr;
    assign conn_oct = sel_octet[conn_idx*8 +: 8];

    // Per-port selection decode; address match plus option support
    for (genvar p = 0; p < NPORTS; p++)
    begin : g_port
        logic [7:0] oct;
        logic amatch;
        assign oct = sel_octet[p*8 +: 8];
        assign amatch = oct[6:OCT_ADDR_LSB] == cfg_addr;
        assign addressed[p] = amatch && (oct[OCT_TOP] ? fac_en
            : ((oct[3:0] & ~opt_mask) == 4'h0));
        assign hold_bit[p] = !oct[OCT_TOP] && oct[OCT_HOLD];
        assign prio_bit[p] = !oct[OCT_TOP] && oct[OCT_PSEL];
    end

    port_arbiter #(
        .NPORTS(NPORTS),
        .IW(IW)
    ) u_arb (
        .pclk(pclk),
        .presetn(presetn),
        .sel_out(sel_out),
        .sel_state(sel_state),
        .addressed(addressed),
        .hold_bit(hold_bit),
        .prio_bit(prio_bit),
        .hold_clr(hold_clr),
        .grant(port_ack),
        .busy(port_busy),
        .drop(port_drop),
        .take(take),
        .conn_idx(conn_idx),
        .hold(hold),
        .hold_both(hold_both)
    );

    // Facility poll: range bit picks low or high eight facilities
    for (genvar i = 0; i < 8; i++)
    begin : g_fac
        logic [3:0] fidx;
        assign fidx = {req_oct[OCT_RANGE], 3'(i)};
        assign fac_hit[i] = |(fac_int[fidx*3 +: 3] & req_oct[2:0]);
    end

    // Poll match is the OR of every requested condition
    assign poll_hit = !req_oct[OCT_TOP] && |(req_oct[6:0] & {dev_busy | (|port_ack),
        dev_ready, !pf_pending, dev_pon, cls_pend});
    assign fac_req = req_oct[OCT_TOP] && (req_oct[6:OCT_ADDR_LSB] == cfg_addr)
        && (req_oct[3:0] != 4'h0);

    // BUS B contents chosen by phase
    always_comb
    begin
        next_b = 8'h00;
        next_oe = 8'h00;
        next_par = 1'b0;
        next_par_oe = 1'b0;
        case (bus_phase)
            PH_SEL_STATUS:
            begin
                if (|port_ack)
                begin
                    next_b = own_bit;
                    next_oe = own_bit;
                end
            end
            PH_SLV_STATUS:
            begin
                if (|port_ack)
                begin
                    next_b = {prev_ok, perr, vend, fac_inval};
                    next_oe = 8'hFF;
                    next_par = ^next_b ^ PAR_ODD;
                    next_par_oe = 1'b1;
                end
            end
            PH_BUSACK:
            begin
                if (|port_ack)
                begin
                    next_oe = 8'hFF;
                    next_par = PAR_ODD;
                    next_par_oe = 1'b1;
                end
            end
            PH_REQUEST:
            begin
                if (poll_hit)
                begin
                    next_b = own_bit;
                    next_oe = own_bit;
                end
            end
            PH_REQUACK:
            begin
                if (fac_req)
                begin
                    next_b = fac_hit; // Parity left released
                    next_oe = fac_hit;
                end
            end
            default: next_b = 8'h00;
        endcase
    end

    // BUS B registered so it is stable across the phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_b_out <= 8'h00;
            bus_b_oe <= 8'h00;
            bus_b_par_out <= 1'b0;
            bus_b_par_oe <= 1'b0;
        end
        else
        begin
            bus_b_out <= next_b;
            bus_b_oe <= next_oe;
            bus_b_par_out <= next_par;
            bus_b_par_oe <= next_par_oe;
        end
    end

    // Octets from BUS A; vendor bits are only stored for software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mstat_last <= 8'h00;
            req_oct <= 8'h00;
            ctl_bad <= 1'b0;
        end
        else
        begin
            if (mstat_stb)
                mstat_last <= bus_a;
            if (req_stb)
                req_oct <= bus_a;
            if (busctl_stb)
                ctl_bad <= !ctl_ok[bus_a[7:6]];
        end
    end
    assign no_xfer = ctl_bad;

    // Facility captured when a facility selection connects
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fac_sel <= 4'h0;
            fac_inval <= 1'b0;
        end
        else if (take)
        begin
            fac_sel <= conn_oct[OCT_TOP] ? conn_oct[3:0] : 4'h0;
            fac_inval <= conn_oct[OCT_TOP] && !fac_valid[conn_oct[3:0]];
        end
    end

    // Parity error held until reported; a new error beats the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            perr <= 1'b0;
        else if (((mstat_stb || busctl_stb) && par_bad) || data_perr)
            perr <= 1'b1;
        else if (bus_phase == PH_SLV_STATUS)
            perr <= 1'b0;
    end

    // Power fail: raised by the poll, cleared by software once wound down
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pf_pending <= 1'b0;
        else if (req_stb && !bus_a[OCT_TOP] && bus_a[4])
            pf_pending <= 1'b1;
        else if (wr && paddr == REG_DEV && pwdata[DEV_PF_DONE])
            pf_pending <= 1'b0;
    end
    assign pfail_alert = pf_pending;

    // Software registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_addr <= RST_ADDR;
            opt_mask <= RST_OPT;
            fac_en <= 1'b0;
            hold_clr <= 1'b0;
            fac_valid <= RST_FAC_VALID;
            {dev_ready, dev_pon, dev_busy, cls_pend, prev_ok, vend} <= '0;
            fac_int <= '0;
            ctl_ok <= RST_CTL_OK;
        end
        else
        begin
            hold_clr <= wr && paddr == REG_CFG && pwdata[CFG_HOLD_CLR];
            if (wr)
            begin
                case (paddr)
                    REG_CFG:
                    begin
                        cfg_addr <= pwdata[2:0];
                        opt_mask <= pwdata[CFG_OPT_LSB +: 4];
                        fac_en <= pwdata[CFG_FAC_EN];
                    end
                    REG_FAC_VALID: fac_valid <= pwdata[15:0];
                    REG_DEV:
                    begin
                        dev_ready <= pwdata[DEV_READY];
                        dev_pon <= pwdata[DEV_PON];
                        dev_busy <= pwdata[DEV_BUSY];
                        cls_pend <= pwdata[DEV_CLS_LSB +: 3];
                        prev_ok <= pwdata[DEV_PREV_OK];
                        vend <= pwdata[DEV_VEND_LSB +: 5];
                    end
                    REG_FAC_LO: fac_int[23:0] <= pwdata[23:0];
                    REG_FAC_HI: fac_int[47:24] <= pwdata[23:0];
                    REG_CTL_OK: ctl_ok <= pwdata[3:0];
                    default: ctl_ok <= ctl_ok;
                endcase
            end
        end
    end

    // Read mux
    always_comb
    begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            REG_CFG: rdata = {23'h0, fac_en, opt_mask, 1'b0, cfg_addr};
            REG_FAC_VALID: rdata = {16'h0, fac_valid};
            REG_DEV: rdata = {19'h0, vend, 1'b0, prev_ok, cls_pend, dev_busy,
                dev_pon, dev_ready};
            REG_FAC_LO: rdata = {8'h0, fac_int[23:0]};
            REG_FAC_HI: rdata = {8'h0, fac_int[47:24]};
            REG_CTL_OK: rdata = {28'h0, ctl_ok};
            REG_STATUS: rdata = {8'h00, fac_sel, perr, fac_inval, ctl_bad, pf_pending,
                mstat_last, 3'h0, hold_both, hold, |port_ack, 2'(conn_idx)};
            default: hit = 1'b0;
        endcase
    end

    // APB slave: one access cycle, data and error registered in setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            if (psel && !penable)
            begin
                prdata <= pwrite ? 32'h0000_0000 : rdata;
                pslverr <= !hit;
            end
        end
    end
endmodule : octet_decoder
`default_nettype wire

// ==== rtl/port_arbiter.sv ====
/*
 Port arbiter: picks which port owns the slave and tracks priority hold.
 Assumes per-port selection attempts already decoded by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module port_arbiter
    import octet_pkg::*;
#(
    parameter int NPORTS = 2,
    parameter int IW = 1
)(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic [NPORTS-1:0] sel_out, // Selection active per port
    input wire logic [NPORTS-1:0] sel_state, // Port in SELECT state
    input wire logic [NPORTS-1:0] addressed, // Octet addresses this slave
    input wire logic [NPORTS-1:0] hold_bit, // Priority hold requested
    input wire logic [NPORTS-1:0] prio_bit, // Priority select requested
    input wire logic hold_clr, // Reset action releases hold
    output logic [NPORTS-1:0] grant, // Connected port
    output logic [NPORTS-1:0] busy, // Busy indication
    output logic [NPORTS-1:0] drop, // Abrupt end of old selection
    output logic take, // New connection pulse
    output logic [IW-1:0] conn_idx, // Connected port index
    output logic hold, // Allegiance in effect
    output logic hold_both // Allegiance from both bits
);
    logic [IW-1:0] hold_idx; // Port holding allegiance
    logic [NPORTS-1:0] elig; // Port may connect now
    logic next_take; // A port wins this cycle
    logic [IW-1:0] next_idx; // Winning port
    logic conn; // Some port connected
    logic conn_in_sel; // Connected port still in SELECT

    assign conn = |grant;
    assign conn_in_sel = sel_state[conn_idx];

    // Eligibility per port; hold by another port blocks, both bits only blocked by both
    for (genvar p = 0; p < NPORTS; p++)
    begin : g_elig
        logic blocked;
        assign blocked = hold && (hold_idx != IW'(p))
            && !(hold_bit[p] && prio_bit[p] && !hold_both);
        assign elig[p] = sel_state[p] && addressed[p] && !blocked && !grant[p]
            && (!conn || (prio_bit[p] && !conn_in_sel));
    end

    // Lowest eligible index wins, so simultaneous requests get one winner
    always_comb
    begin
        next_take = 1'b0;
        next_idx = conn_idx;
        for (int p = NPORTS - 1; p >= 0; p--)
        begin
            if (elig[p])
            begin
                next_take = 1'b1;
                next_idx = IW'(p);
            end
        end
    end

    // Connection, preemption and busy answers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            grant <= '0;
            drop <= '0;
            take <= 1'b0;
            conn_idx <= '0;
            busy <= '0;
        end
        else
        begin
            take <= next_take;
            if (next_take)
            begin
                grant <= NPORTS'(1) << next_idx;
                drop <= grant;
                conn_idx <= next_idx;
                busy <= sel_state & addressed & ~(NPORTS'(1) << next_idx);
            end
            else
            begin
                grant <= grant & sel_out; // Deselection frees the port
                drop <= '0;
                busy <= sel_state & addressed & ~grant;
            end
        end
    end

    // Allegiance: each new selection replaces it, reset action clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold <= 1'b0;
            hold_both <= 1'b0;
            hold_idx <= '0;
        end
        else if (next_take)
        begin
            hold <= hold_bit[next_idx];
            hold_both <= hold_bit[next_idx] & prio_bit[next_idx];
            hold_idx <= next_idx;
        end
        else if (hold_clr)
        begin
            hold <= 1'b0;
            hold_both <= 1'b0;
        end
    end
endmodule : port_arbiter
`default_nettype wire

// ==== sim/bus_master_model.sv ====
/*
 Behavioural master on the far side of the parallel bus.
 Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
    import octet_pkg::*;
#(
    parameter int NPORTS = 2
)(
    input wire logic pclk, // Clock
    output logic [NPORTS-1:0] sel_out, // Selection active
    output logic [NPORTS-1:0] sel_state, // In SELECT
    output logic [8*NPORTS-1:0] sel_octet, // Octets
    output logic [7:0] bus_a, // BUS A
    output logic bus_a_par, // Odd parity
    output logic mstat_stb, // Master status
    output logic busctl_stb, // Bus control
    output logic req_stb, // Request
    output logic data_perr, // Never raised
    output var phase_t bus_phase // Phase
);
    // Quiet bus at time zero
    initial
    begin
        {sel_out, sel_state, sel_octet, bus_a, mstat_stb, busctl_stb, req_stb, data_perr} = '0;
        bus_a_par = 1'b1;
        bus_phase = PH_IDLE;
    end

    // Masked ports, s is {in SELECT, active}; a left octet is inverted, so leaving twice restores the stale value
    task sel(input logic [NPORTS-1:0] m, input logic [7:0] o, input logic [1:0] s);
        @(posedge pclk);
        for (int p = 0; p < NPORTS; p++)
            if (m[p])
            begin
                sel_octet[8*p+:8] <= s[1] ? o : ~sel_octet[8*p+:8];
                sel_state[p] <= s[1];
                sel_out[p] <= s[0];
            end
    endtask : sel

    // One octet with a one-cycle strobe; k picks mstat, busctl, req
    task put(input logic [7:0] o, input int k);
        @(posedge pclk);
        bus_a <= o;
        bus_a_par <= ~^o;
        {req_stb, busctl_stb, mstat_stb} <= 3'(1 << k);
        @(posedge pclk);
        {req_stb, busctl_stb, mstat_stb} <= 3'b000;
        bus_a <= ~o;
    endtask : put

    // Move the interface phase
    task ph(input phase_t p);
        @(posedge pclk);
        bus_phase <= p;
    endtask : ph
endmodule : bus_master_model
`default_nettype wire

// ==== sim/octet_decoder_assertions.sv ====
/*
 Port checker for the octet decoder.
 Assumes one clock domain and an async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module octet_decoder_assertions
    import octet_pkg::*;
#(
    parameter int NPORTS = 2
)(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic [NPORTS-1:0] sel_state, // In SELECT
    input wire logic [NPORTS-1:0] port_ack, // Acknowledge
    input wire logic [NPORTS-1:0] port_busy, // Busy
    input wire logic [NPORTS-1:0] port_drop, // Ended
    input wire phase_t bus_phase, // Phase
    input wire logic [7:0] bus_b_out, // BUS B value
    input wire logic [7:0] bus_b_oe, // BUS B enables
    input wire logic bus_b_par_out, // Parity value
    input wire logic bus_b_par_oe // Parity enable
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Connected port in select status
    sequence s_selstat;
        bus_phase == PH_SEL_STATUS && |port_ack;
    endsequence
    // Connected port in bus acknowledge
    sequence s_busack;
        bus_phase == PH_BUSACK && |port_ack;
    endsequence
    ack_sel_a: assert property ($rose(port_ack[0]) |-> $past(sel_state[0]))
        else $error("ack without selection");
    ack_onehot_a: assert property ($onehot0(port_ack))
        else $error("two ports acknowledged");
    ack_busy_a: assert property ((port_ack & port_busy) == '0)
        else $error("port both busy and acked");
    selstat_bit_a: assert property (s_selstat |=> $onehot(bus_b_oe)
        && bus_b_out == bus_b_oe && !bus_b_par_oe) else $error("bad select status");
    busack_zero_a: assert property (s_busack |=> bus_b_oe == 8'hFF
        && bus_b_out == 8'h00 && bus_b_par_out && bus_b_par_oe) else $error("bad bus ack");
    busack_stable_a: assert property (s_busack ##1 s_busack |=> $stable(bus_b_out))
        else $error("bus ack not stable");
    idle_release_a: assert property (bus_phase == PH_IDLE |=> bus_b_oe == 8'h00)
        else $error("bus driven while idle");
    drop_pulse_a: assert property (port_drop[0] |=> !port_drop[0])
        else $error("drop longer than a pulse");
endmodule : octet_decoder_assertions
`default_nettype wire

// ==== sim/octet_decoder_tb_top.sv ====
/*
 Bench for the octet decoder: APB tasks plus a master model.
 Assumes the package and design are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module octet_decoder_tb_top
    import octet_pkg::*;
;
    localparam int NPORTS = 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, drop_seen;
    logic [7:0] paddr, bus_a, bus_b_out, bus_b_oe;
    logic [31:0] pwdata, prdata, rd;
    logic [NPORTS-1:0] sel_out, sel_state, port_ack, port_busy, port_drop;
    logic [8*NPORTS-1:0] sel_octet;
    logic bus_a_par, mstat_stb, busctl_stb, req_stb, data_perr;
    logic bus_b_par_out, bus_b_par_oe, no_xfer, pfail_alert;
    phase_t bus_phase;
    int n_fail = 0;
    int comparisons = 0;
    logic [7:0] bad_oct [3] = '{8'h04, 8'h10, 8'h80}; // Option, address, facility
    logic [15:0] poll [10] = '{16'h0120, 16'h0040, 16'h0007, 16'h0008,
        16'h0101, 16'h0102, 16'h0104, 16'h0161, 16'h0184, 16'h008C}; // Expected enables, request

    octet_decoder #(.NPORTS(NPORTS)) dut_u (.*);
    bus_master_model #(.NPORTS(NPORTS)) mm (.*);

    // 100 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Latch drop pulses, too short to poll
    always @(posedge pclk)
        if (port_drop[0])
            drop_seen <= 1'b1;

    // Compare and count
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // Let n clock edges pass
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    // One APB transfer, held until pready; only the watchdog ends a hang
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Counts, verdict, end of run
    task stop_test;
        $display("checks %0d fails %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, drop_seen} = '0;
        repeat (6) @(posedge pclk);
        chk("rst", {port_ack, port_busy, bus_b_oe, no_xfer}, '0);
        presetn <= 1'b1;
        apb(1'b0, REG_CFG, '0);
        chk("cfg", rd, 32'h0000_0030);
        apb(1'b0, REG_FAC_VALID, '0);
        chk("fac_valid", rd, 32'h0000_FFFF);
        apb(1'b0, 8'h1C, '0);
        chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, REG_DEV, 32'h0000_0041);
        foreach (bad_oct[i])
        begin
            mm.sel(2'b01, bad_oct[i], 2'b11);
            wt(3);
            chk("refuse", {port_ack, port_busy}, '0);
            mm.sel(2'b01, 8'h00, 2'b00);
        end
        mm.sel(2'b01, 8'h02, 2'b11);
        mm.sel(2'b01, 8'h00, 2'b01);
        mm.ph(PH_SEL_STATUS);
        wt(3);
        chk("sel_stat", {port_ack, bus_b_oe, bus_b_out}, 18'h10101);
        mm.ph(PH_BUSACK);
        wt(3);
        chk("busack", {bus_b_par_oe, bus_b_par_out, bus_b_oe, bus_b_out}, 18'h3FF00);
        mm.ph(PH_SLV_STATUS);
        wt(3);
        chk("slv_ok", bus_b_out[7], 1'b1);
        mm.ph(PH_IDLE);
        mm.sel(2'b01, 8'h00, 2'b00);
        mm.sel(2'b10, 8'h01, 2'b11);
        wt(3);
        chk("hold_blk", port_ack, 2'b00);
        mm.sel(2'b10, 8'h03, 2'b11);
        wt(3);
        chk("both_win", port_ack, 2'b10);
        mm.sel(2'b10, 8'h00, 2'b00);
        mm.sel(2'b01, 8'h01, 2'b11);
        wt(3);
        chk("both_blk", port_ack, 2'b00);
        mm.sel(2'b01, 8'h00, 2'b00);
        apb(1'b1, REG_CFG, 32'h0000_0330);
        mm.sel(2'b11, 8'h01, 2'b11);
        wt(3);
        chk("tie", {port_ack, port_busy}, 4'b0110);
        mm.sel(2'b11, 8'h00, 2'b00);
        mm.sel(2'b01, 8'h00, 2'b11);
        mm.sel(2'b01, 8'h00, 2'b01);
        drop_seen <= 1'b0;
        mm.sel(2'b10, 8'h01, 2'b11);
        wt(3);
        chk("preempt", {drop_seen, port_ack}, 3'b110);
        mm.sel(2'b11, 8'h00, 2'b00);
        apb(1'b1, REG_FAC_VALID, 32'h1);
        mm.sel(2'b01, 8'h85, 2'b11);
        wt(1);
        mm.sel(2'b01, 8'h00, 2'b01);
        mm.ph(PH_SLV_STATUS);
        wt(3);
        chk("fac_inval", bus_b_out[0], 1'b1);
        mm.ph(PH_IDLE);
        mm.sel(2'b01, 8'h00, 2'b00);
        apb(1'b1, REG_FAC_LO, 32'h4);
        foreach (poll[i])
        begin
            if (i == 4)
                apb(1'b1, REG_DEV, 32'h0000_0079);
            mm.put(poll[i][7:0], 2);
            mm.ph(poll[i][7] ? PH_REQUACK : PH_REQUEST);
            wt(3);
            chk("poll", bus_b_oe, poll[i][15:8]);
            mm.ph(PH_IDLE);
        end
        mm.put(8'h10, 2);
        mm.ph(PH_REQUEST);
        wt(3);
        chk("pf_wait", {pfail_alert, bus_b_oe}, 9'h100);
        apb(1'b1, REG_DEV, 32'h0000_4079);
        wt(3);
        chk("pf_ack", bus_b_oe, 8'h01);
        mm.ph(PH_IDLE);
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, REG_CTL_OK, i ? 32'h0000_000F : 32'h0);
            mm.put(i ? 8'h3F : 8'h00, 1);
            wt(2);
            chk("ctl", no_xfer, !i);
        end
        stop_test();
    end
endmodule : octet_decoder_tb_top

bind octet_decoder octet_decoder_assertions #(.NPORTS(NPORTS)) chk_u (.*);
`default_nettype wire
